// [verilog/ddl_pkg.sv]
// shared constants and types for the dual converter serial load control
package ddl_pkg;

    // ====================================================================
    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h17;
    localparam logic [23:0] SHIFT_RESET = 24'h000000;
    localparam int CMD_MSB = 21;
    localparam int CMD_LSB = 19;
    localparam int ADDR_MSB = 18;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int REF_SEL_BIT = 0;

    // ====================================================================
    // commands and channel addresses
    localparam logic [2:0] CMD_WRITE_INPUT = 3'h0;
    localparam logic [2:0] CMD_UPDATE_CONV = 3'h1;
    localparam logic [2:0] CMD_WRITE_UPDATE_ALL = 3'h2;
    localparam logic [2:0] CMD_WRITE_UPDATE_ONE = 3'h3;
    localparam logic [2:0] CMD_REF_SELECT = 3'h7;
    localparam logic [2:0] ADDR_BOTH = 3'h7;

    // ====================================================================
    // codes
    localparam int CHANNELS = 2;
    localparam int DATA_W = 16;
    localparam int RESOLUTION = 16;
    localparam logic [DATA_W-1:0] ZERO_SCALE = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_MASK = 16'hFFFF << (DATA_W - RESOLUTION);

    // ====================================================================
    // synchroniser
    localparam int PIN_W = 5;
    localparam logic [PIN_W-1:0] PINS_IDLE = 5'h1B;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic din;
        logic load_strobe_n;
        logic async_clear_n;
    } ddl_pins_t;

    typedef struct packed {
        logic [DATA_W-1:0] code_b;
        logic [DATA_W-1:0] code_a;
    } ddl_codes_t;

endpackage : ddl_pkg

// [verilog/ddl_sync.sv]
// two-flop synchroniser for the serial and strobe pins
`timescale 1ns/1ps
module ddl_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // ====================================================================
    // first stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            meta <= INIT;
            o_sync <= INIT;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : ddl_sync

// [verilog/ddl_ctrl.sv]
// serial load, strobe and clear control for a dual-channel converter
//
// Contract
// - load strobe low moves pending inputs to converters
// - clear acts on its falling edge only
// - strobe ignored while clear held low
// - clear zeroes all input and converter registers
// - clear mode ends on next 24th edge
// - clear during a write aborts that write
// - shift register enabled only while sync low
// - data sampled on serial clock falling edges
// - update only after 24th serial clock edge
// - early sync rise discards partial write
// - input shift register is 24 bits
// - reference pin input by default, output once selected
// - converter codes are straight binary
`timescale 1ns/1ps
module ddl_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    input wire logic i_load_strobe_n,
    input wire logic i_async_clear_n,
    output ddl_pkg::ddl_codes_t o_codes,
    output logic o_shared_reference_pin_oe,
    output logic o_clear_mode,
    output logic o_frame_active
);
    import ddl_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE,
        ST_ABORT
    } ddl_state_t;

    ddl_pins_t pins_raw;
    ddl_pins_t pins;
    logic sclk_prev;
    logic clear_prev;
    logic sclk_fall;
    logic clear_fall;
    logic load_active;
    ddl_state_t state;
    logic [CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] shift_reg;
    logic commit;
    logic [CHANNELS-1:0][DATA_W-1:0] input_reg;
    logic [CHANNELS-1:0][DATA_W-1:0] conv_reg;
    logic [CHANNELS-1:0] pending;
    logic [CHANNELS-1:0][DATA_W-1:0] next_input_reg;
    logic [CHANNELS-1:0][DATA_W-1:0] next_conv_reg;
    logic [CHANNELS-1:0] next_pending;
    logic [2:0] word_cmd;
    logic [2:0] word_addr;
    logic [DATA_W-1:0] word_data;

    function automatic logic addr_hit(input logic [2:0] addr, input int ch);
        addr_hit = (addr == ADDR_BOTH) || (addr == 3'(ch));
    endfunction : addr_hit

    // ====================================================================
    // pin synchronisation and edge detection
    assign pins_raw = '{sclk: i_sclk, sync_n: i_sync_n, din: i_din,
                        load_strobe_n: i_load_strobe_n, async_clear_n: i_async_clear_n};

    ddl_sync #(.W(PIN_W), .INIT(PINS_IDLE)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sclk_prev <= PINS_IDLE[4];
            clear_prev <= PINS_IDLE[0];
        end else begin
            sclk_prev <= pins.sclk;
            clear_prev <= pins.async_clear_n;
        end
    end

    assign sclk_fall = sclk_prev && !pins.sclk;
    assign clear_fall = clear_prev && !pins.async_clear_n;
    assign load_active = !pins.load_strobe_n && pins.async_clear_n;

    // ====================================================================
    // frame state
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (!pins.sync_n && !clear_fall) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (clear_fall) begin
                        state <= ST_ABORT;
                    end else if (pins.sync_n) begin
                        state <= ST_IDLE;
                    end else if (sclk_fall && bit_cnt == CNT_LAST) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE, ST_ABORT: begin
                    if (pins.sync_n) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ====================================================================
    // shift register and bit counter
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || state != ST_SHIFT) begin
            bit_cnt <= CNT_RESET;
            shift_reg <= SHIFT_RESET;
        end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + CNT_W'(1);
            shift_reg <= {shift_reg[FRAME_BITS-2:0], pins.din};
        end
    end

    // commit fires one cycle after the 24th edge, once the word is whole
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            commit <= 1'b0;
        end else begin
            commit <= (state == ST_SHIFT) && !pins.sync_n && !clear_fall
                && sclk_fall && bit_cnt == CNT_LAST;
        end
    end

    assign word_cmd = shift_reg[CMD_MSB:CMD_LSB];
    assign word_addr = shift_reg[ADDR_MSB:ADDR_LSB];
    assign word_data = shift_reg[DATA_MSB:0] & CODE_MASK;

    // ====================================================================
    // input and converter registers
    always_comb begin
        next_input_reg = input_reg;
        next_conv_reg = conv_reg;
        next_pending = pending;
        if (commit) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                case (word_cmd)
                    CMD_WRITE_INPUT: begin
                        if (addr_hit(word_addr, ch)) begin
                            next_input_reg[ch] = word_data;
                            next_pending[ch] = 1'b1;
                        end
                    end
                    CMD_UPDATE_CONV: begin
                        if (addr_hit(word_addr, ch)) begin
                            next_conv_reg[ch] = input_reg[ch];
                            next_pending[ch] = 1'b0;
                        end
                    end
                    CMD_WRITE_UPDATE_ALL: begin
                        if (addr_hit(word_addr, ch)) begin
                            next_input_reg[ch] = word_data;
                        end
                        next_conv_reg[ch] = next_input_reg[ch];
                        next_pending[ch] = 1'b0;
                    end
                    CMD_WRITE_UPDATE_ONE: begin
                        if (addr_hit(word_addr, ch)) begin
                            next_input_reg[ch] = word_data;
                            next_conv_reg[ch] = word_data;
                            next_pending[ch] = 1'b0;
                        end
                    end
                    default: begin
                        next_pending[ch] = pending[ch];
                    end
                endcase
            end
        end
        // a level, so a strobe tied low updates as soon as data lands
        if (load_active) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (next_pending[ch]) begin
                    next_conv_reg[ch] = next_input_reg[ch];
                    next_pending[ch] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset || clear_fall) begin
            input_reg <= {CHANNELS{ZERO_SCALE}};
            conv_reg <= {CHANNELS{ZERO_SCALE}};
            pending <= '0;
        end else begin
            input_reg <= next_input_reg;
            conv_reg <= next_conv_reg;
            pending <= next_pending;
        end
    end

    // ====================================================================
    // reference selection and clear mode
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_shared_reference_pin_oe <= 1'b0;
        end else if (commit && word_cmd == CMD_REF_SELECT) begin
            o_shared_reference_pin_oe <= shift_reg[REF_SEL_BIT];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_clear_mode <= 1'b0;
        end else if (clear_fall) begin
            o_clear_mode <= 1'b1;
        end else if (commit) begin
            o_clear_mode <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_codes <= '0;
            o_frame_active <= 1'b0;
        end else begin
            o_codes <= '{code_b: conv_reg[1], code_a: conv_reg[0]};
            o_frame_active <= (state == ST_SHIFT);
        end
    end
endmodule : ddl_ctrl

// [test/ddl_host.sv]
// serial host model driving the frame sync, serial clock and data pins
`timescale 1ns/1ps
module ddl_host (
    input wire logic i_ref_clk,
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_din
);
    // ====================================================================
    // frame driver, serial clock parked high outside frames
    initial begin
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_din = 1'b0;
    end
    task automatic send(input logic [23:0] w, input int n);
        o_sync_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        for (int i = 0; i < n; i++) begin
            o_din <= w[23-i];
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b1;
        end
        repeat (4) @(posedge i_ref_clk);
        o_sync_n <= 1'b1;
        o_din <= ~o_din;
        repeat (4) @(posedge i_ref_clk);
    endtask : send
endmodule : ddl_host

// [test/ddl_ctrl_props.sv]
// concurrent checks on the serial load control ports
`timescale 1ns/1ps
module ddl_ctrl_props (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    input wire logic i_load_strobe_n,
    input wire logic i_async_clear_n,
    input ddl_pkg::ddl_codes_t o_codes,
    input wire logic o_shared_reference_pin_oe,
    input wire logic o_clear_mode,
    input wire logic o_frame_active
);
    import ddl_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    // ====================================================================
    // sequences
    sequence s_clear_hit;
        $fell(i_async_clear_n);
    endsequence
    sequence s_quiet;
        (i_sync_n && i_load_strobe_n && i_async_clear_n) [*8];
    endsequence
    // ====================================================================
    // assertions
    a_reset_idle: assert property ($fell(i_reset) |->
        (o_codes == 32'h0 && !o_shared_reference_pin_oe && !o_clear_mode && !o_frame_active))
        else $error("outputs not idle after reset");
    a_clear_zeroes: assert property (s_clear_hit |->
        ##[1:8] (o_codes == 32'h0 && o_clear_mode))
        else $error("clear did not zero the codes");
    a_strobe_ignored: assert property ((!i_async_clear_n && i_sync_n) [*8] |->
        $stable(o_codes))
        else $error("codes moved while clear held low");
    a_codes_quiet: assert property (s_quiet |-> $stable(o_codes))
        else $error("codes moved with no frame, strobe or clear");
    a_sync_enables: assert property (i_sync_n [*6] |-> !o_frame_active)
        else $error("frame active with sync high");
    a_ref_stable: assert property (i_sync_n [*8] |-> $stable(o_shared_reference_pin_oe))
        else $error("reference enable moved outside a frame");
    a_clear_holds: assert property ((o_clear_mode && i_sync_n) [*8] |=> o_clear_mode)
        else $error("clear mode left without a frame");
    a_clear_exit: assert property ($fell(o_clear_mode) |-> $past(i_sync_n, 4) == 1'b0)
        else $error("clear mode left outside a frame");
endmodule : ddl_ctrl_props

bind ddl_ctrl ddl_ctrl_props u_props (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_sync_n(i_sync_n),
    .i_din(i_din), .i_load_strobe_n(i_load_strobe_n), .i_async_clear_n(i_async_clear_n),
    .o_codes(o_codes), .o_shared_reference_pin_oe(o_shared_reference_pin_oe),
    .o_clear_mode(o_clear_mode), .o_frame_active(o_frame_active)
);

// [test/tb.sv]
// self-checking bench for the serial load control
`timescale 1ns/1ps
module tb;
    import ddl_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic ld_n = 1'b1;
    logic clr_n = 1'b1;
    logic sclk, sync_n, din, oe, clr_mode, frame;
    ddl_codes_t codes;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    always #10 i_ref_clk = ~i_ref_clk;
    ddl_host u_ddl_host (.i_ref_clk(i_ref_clk), .o_sclk(sclk), .o_sync_n(sync_n), .o_din(din));
    ddl_ctrl u_ddl_ctrl (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sclk(sclk), .i_sync_n(sync_n),
        .i_din(din), .i_load_strobe_n(ld_n), .i_async_clear_n(clr_n), .o_codes(codes),
        .o_shared_reference_pin_oe(oe), .o_clear_mode(clr_mode), .o_frame_active(frame)
    );
    // ====================================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [23:0] w(input logic [2:0] c, input logic [2:0] a,
                                      input logic [15:0] d);
        return {2'h0, c, a, d};
    endfunction : w
    task automatic xfer(input logic [23:0] v, input int n);
        u_ddl_host.send(v, n);
        repeat (12) @(posedge i_ref_clk);
    endtask : xfer
    task automatic pulse_ld;
        ld_n <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        ld_n <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
    endtask : pulse_ld
    // ====================================================================
    // scenarios
    task automatic t_write;
        fork
            xfer(w(CMD_WRITE_UPDATE_ONE, 3'h0, 16'h1234), 24);
            begin
                repeat (40) @(posedge i_ref_clk);
                chk({31'h0, frame}, 32'h1);
            end
        join
        chk({31'h0, frame}, 32'h0);
        chk(codes, 32'h00001234);
        xfer(w(CMD_WRITE_UPDATE_ONE, 3'h1, 16'hFFFF), 24);
        chk(codes, 32'hFFFF1234);
        xfer(w(CMD_WRITE_UPDATE_ONE, 3'h0, 16'hABCD), 23);
        chk(codes, 32'hFFFF1234);
        $display("test write done");
    endtask : t_write
    task automatic t_strobe;
        xfer(w(CMD_WRITE_INPUT, ADDR_BOTH, 16'h5555), 24);
        chk(codes, 32'hFFFF1234);
        pulse_ld();
        chk(codes, 32'h55555555);
        ld_n <= 1'b0;
        xfer(w(CMD_WRITE_INPUT, 3'h1, 16'h4321), 24);
        chk(codes, 32'h43215555);
        ld_n <= 1'b1;
        $display("test strobe done");
    endtask : t_strobe
    task automatic t_ref;
        chk({31'h0, oe}, 32'h0);
        xfer(w(CMD_REF_SELECT, 3'h0, 16'h0001), 24);
        chk({31'h0, oe}, 32'h1);
        xfer(w(CMD_REF_SELECT, 3'h0, 16'h0000), 23);
        chk({31'h0, oe}, 32'h1);
        xfer(w(CMD_REF_SELECT, 3'h0, 16'h0000), 24);
        chk({31'h0, oe}, 32'h0);
        $display("test ref done");
    endtask : t_ref
    task automatic t_clear;
        fork
            xfer(w(CMD_WRITE_UPDATE_ONE, 3'h1, 16'h2222), 24);
            begin
                repeat (60) @(posedge i_ref_clk);
                clr_n <= 1'b0;
            end
        join
        chk(codes, 32'h0);
        chk({31'h0, clr_mode}, 32'h1);
        xfer(w(CMD_WRITE_INPUT, 3'h0, 16'h7777), 24);
        chk({31'h0, clr_mode}, 32'h0);
        pulse_ld();
        chk(codes, 32'h0);
        clr_n <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        pulse_ld();
        chk(codes, 32'h00007777);
        $display("test clear done");
    endtask : t_clear
    task automatic t_cmds;
        xfer(w(CMD_UPDATE_CONV, 3'h1, 16'h0000), 24);
        chk(codes, 32'h00007777);
        xfer(w(CMD_WRITE_UPDATE_ALL, 3'h1, 16'h9999), 24);
        chk(codes, 32'h99997777);
        $display("test commands done");
    endtask : t_cmds
    // ====================================================================
    // run control
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        t_write();
        t_strobe();
        t_ref();
        t_clear();
        t_cmds();
        end_of_test();
    end
endmodule : tb
